// *** include/spf_pkg.sv ***
// Package for the shared pad function select block
package spf_pkg;

  // **************************************************************
  // Register bus geometry
  // **************************************************************
  localparam int unsigned SPF_ADDR_W = 8;
  localparam int unsigned SPF_DATA_W = 32;
  localparam int unsigned SPF_PADS = 5;

  // **************************************************************
  // Register byte offsets
  // **************************************************************
  localparam logic [7:0] SPF_OFS_FUNC_EN = 8'h00;
  localparam logic [7:0] SPF_OFS_PORT_DATA = 8'h04;
  localparam logic [7:0] SPF_OFS_PORT_DIR = 8'h08;
  localparam logic [7:0] SPF_OFS_PAD_LEVEL = 8'h0c;
  localparam logic [7:0] SPF_OFS_PORT_OWN = 8'h10;

  // **************************************************************
  // Pad index within the five-pad group
  // **************************************************************
  localparam int unsigned SPF_PAD_B16 = 0;
  localparam int unsigned SPF_PAD_B17 = 1;
  localparam int unsigned SPF_PAD_B20 = 2;
  localparam int unsigned SPF_PAD_B21 = 3;
  localparam int unsigned SPF_PAD_B22 = 4;

  // **************************************************************
  // Function enable field positions and width
  // **************************************************************
  localparam int unsigned SPF_FE_PG5 = 0;
  localparam int unsigned SPF_FE_CAN_RX = 1;
  localparam int unsigned SPF_FE_IRQ6 = 2;
  localparam int unsigned SPF_FE_PG6 = 3;
  localparam int unsigned SPF_FE_CAN_TX = 4;
  localparam int unsigned SPF_FE_ADC1 = 5;
  localparam int unsigned SPF_FE_CAP2 = 6;
  localparam int unsigned SPF_FE_ADC2 = 7;
  localparam int unsigned SPF_FE_CAP3 = 8;
  localparam int unsigned SPF_FE_PWIDTH = 9;
  localparam int unsigned SPF_FE_W = 10;

  // **************************************************************
  // Values after reset
  // **************************************************************
  localparam logic [9:0] SPF_RST_FUNC_EN = 10'h000;
  localparam logic [4:0] SPF_RST_PORT_DATA = 5'h00;
  localparam logic [4:0] SPF_RST_PORT_DIR = 5'h00;
  // Idle level of the CAN receive input when the pad is not selected
  localparam logic SPF_CAN_RX_IDLE = 1'b1;

  // **************************************************************
  // Carrier types
  // **************************************************************
  // Pulse generator and CAN transmit levels heading for the pads
  typedef struct packed {
    logic pulse_gen_out_5;
    logic pulse_gen_out_6;
    logic can_transmit_line;
  } spf_periph_out_t;

  // Pad levels handed to the on-chip peripherals
  typedef struct packed {
    logic can_receive_line;
    logic ext_irq_line_6;
    logic adc1_ext_trigger;
    logic capture_trigger_2;
    logic adc2_ext_trigger;
    logic capture_trigger_3;
    logic pulse_width_meas_in;
  } spf_periph_in_t;

  // Level and enable of each pad
  typedef struct packed {
    logic [4:0] level;
    logic [4:0] oe;
  } spf_pad_drive_t;

endpackage

// *** src/spf_pin_select.sv ***
// Pin sharing logic for five pads shared by peripherals and port bits
//
// Operation
// R1: Pulse gen 5 drives pad when enabled
// R2: Port bit sixteen only when both disabled
// R3: CAN receive fed from pad when enabled
// R4: Software keeps port off during CAN receive
// R5: Interrupt 6 sampled when enabled; port off (the logic leaves pad 16 to the port; software must turn the port off)
// R6: Pulse gen 6 drives pad when enabled
// R7: CAN transmit drives pad when enabled
// R8: Port bit seventeen only when both disabled
// R9: ADC1 trigger from pad when pin selected
// R10: Capture 2 trigger from same pad
// R11: Port bit twenty when either setting off
// R12: ADC2 trigger from pad when pin selected
// R13: Capture 3 trigger from same pad
// R14: Port bit twenty-one when either setting off
// R15: Pulse width input from pad when enabled
// R16: Port bit twenty-two when counter disabled
// R17: Software keeps port off on trigger pads
// R18: All input functions see pad in parallel
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps

module spf_pin_select
  import spf_pkg::*;
#(
  parameter int unsigned ADDR_W = spf_pkg::SPF_ADDR_W,
  parameter int unsigned DATA_W = spf_pkg::SPF_DATA_W
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  input wire spf_pkg::spf_periph_out_t periph_out,
  output spf_pkg::spf_periph_in_t periph_in,
  input wire logic [spf_pkg::SPF_PADS-1:0] pad_in,
  output logic [spf_pkg::SPF_PADS-1:0] pad_out,
  output logic [spf_pkg::SPF_PADS-1:0] pad_oe
);
  import spf_pkg::*;

  // **************************************************************
  // Registers
  // **************************************************************
  logic [SPF_FE_W-1:0] func_en;
  logic [SPF_PADS-1:0] port_data;
  logic [SPF_PADS-1:0] port_dir;
  logic [SPF_PADS-1:0] port_own;
  spf_pad_drive_t next_drive;
  spf_periph_in_t next_periph_in;
  logic [DATA_W-1:0] next_rdata;

  // Zero-extend a pad-wide field into a bus word
  function automatic logic [DATA_W-1:0] pad_word(
    input logic [SPF_PADS-1:0] v
  );
    pad_word = {{(DATA_W-SPF_PADS){1'b0}}, v};
  endfunction

  // Match the bus address against a byte offset
  function automatic logic hit(
    input logic [ADDR_W-1:0] a,
    input logic [7:0] ofs
  );
    hit = (a == ADDR_W'(ofs));
  endfunction

  // **************************************************************
  // Ownership of each pad output driver
  // **************************************************************
  // Port bit loses pad 16 to pulse gen 5 or CAN receive, pad 17 to either output, pad 22 to pulse width, pads 20 and 21 only when both triggers are on
  always_comb begin
    port_own = '0;
    port_own[SPF_PAD_B16] = !func_en[SPF_FE_PG5] &&
                            !func_en[SPF_FE_CAN_RX]; // [R2]
    port_own[SPF_PAD_B17] = !func_en[SPF_FE_PG6] &&
                            !func_en[SPF_FE_CAN_TX]; // [R8]
    // Either trigger setting off is enough to free this pad
    port_own[SPF_PAD_B20] = !func_en[SPF_FE_ADC1] ||
                            !func_en[SPF_FE_CAP2]; // [R11]
    port_own[SPF_PAD_B21] = !func_en[SPF_FE_ADC2] ||
                            !func_en[SPF_FE_CAP3]; // [R14]
    port_own[SPF_PAD_B22] = !func_en[SPF_FE_PWIDTH]; // [R16]
  end

  // **************************************************************
  // Pad output selection
  // **************************************************************
  // Pulse generator wins pad 17 if software enables both outputs
  always_comb begin
    next_drive.level = '0;
    next_drive.oe = '0;
    // Pad 16: pulse generator 5 or port
    if (func_en[SPF_FE_PG5]) begin
      next_drive.level[SPF_PAD_B16] = periph_out.pulse_gen_out_5; // [R1]
      next_drive.oe[SPF_PAD_B16] = 1'b1; // [R1]
    end else if (port_own[SPF_PAD_B16]) begin
      next_drive.level[SPF_PAD_B16] = port_data[SPF_PAD_B16];
      next_drive.oe[SPF_PAD_B16] = port_dir[SPF_PAD_B16];
    end
    // Pad 17: pulse generator 6, CAN transmit, or port
    if (func_en[SPF_FE_PG6]) begin
      next_drive.level[SPF_PAD_B17] = periph_out.pulse_gen_out_6; // [R6]
      next_drive.oe[SPF_PAD_B17] = 1'b1; // [R6]
    end else if (func_en[SPF_FE_CAN_TX]) begin
      next_drive.level[SPF_PAD_B17] =
        periph_out.can_transmit_line; // [R7]
      next_drive.oe[SPF_PAD_B17] = 1'b1; // [R7]
    end else begin
      next_drive.level[SPF_PAD_B17] = port_data[SPF_PAD_B17];
      next_drive.oe[SPF_PAD_B17] = port_dir[SPF_PAD_B17];
    end
    // Pads 20 to 22 carry inputs only, so the port is the sole driver
    if (port_own[SPF_PAD_B20]) begin
      next_drive.level[SPF_PAD_B20] = port_data[SPF_PAD_B20];
      next_drive.oe[SPF_PAD_B20] = port_dir[SPF_PAD_B20];
    end
    if (port_own[SPF_PAD_B21]) begin
      next_drive.level[SPF_PAD_B21] = port_data[SPF_PAD_B21];
      next_drive.oe[SPF_PAD_B21] = port_dir[SPF_PAD_B21];
    end
    if (port_own[SPF_PAD_B22]) begin
      next_drive.level[SPF_PAD_B22] = port_data[SPF_PAD_B22];
      next_drive.oe[SPF_PAD_B22] = port_dir[SPF_PAD_B22];
    end
  end

  // Pad outputs from flip-flops so glitches never reach the board
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pad_out <= '0;
      pad_oe <= '0;
    end else if (clk_en) begin
      pad_out <= next_drive.level;
      pad_oe <= next_drive.oe;
    end
  end

  // **************************************************************
  // Pad inputs toward the peripherals
  // **************************************************************
  // Every input taps the pad itself, whoever drives it; software must
  // keep the port driver off on input pads unless it means to drive
  always_comb begin
    next_periph_in.can_receive_line = func_en[SPF_FE_CAN_RX] ?
      pad_in[SPF_PAD_B16] : SPF_CAN_RX_IDLE; // [R3] [R4]
    next_periph_in.ext_irq_line_6 = func_en[SPF_FE_IRQ6] &&
      pad_in[SPF_PAD_B16]; // [R5] [R18]
    next_periph_in.adc1_ext_trigger = func_en[SPF_FE_ADC1] &&
      pad_in[SPF_PAD_B20]; // [R9] [R17]
    next_periph_in.capture_trigger_2 = func_en[SPF_FE_CAP2] &&
      pad_in[SPF_PAD_B20]; // [R10] [R18]
    next_periph_in.adc2_ext_trigger = func_en[SPF_FE_ADC2] &&
      pad_in[SPF_PAD_B21]; // [R12] [R17]
    next_periph_in.capture_trigger_3 = func_en[SPF_FE_CAP3] &&
      pad_in[SPF_PAD_B21]; // [R13] [R18]
    next_periph_in.pulse_width_meas_in = func_en[SPF_FE_PWIDTH] &&
      pad_in[SPF_PAD_B22]; // [R15]
  end

  // Registered toward the peripherals, one cycle behind the pad
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      periph_in <= '0;
      periph_in.can_receive_line <= SPF_CAN_RX_IDLE;
    end else if (clk_en) begin
      periph_in <= next_periph_in;
    end
  end

  // **************************************************************
  // Register writes
  // **************************************************************
  // Function enables
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      func_en <= SPF_RST_FUNC_EN;
    end else if (clk_en && reg_write &&
                 hit(reg_addr, SPF_OFS_FUNC_EN)) begin
      func_en <= reg_wdata[SPF_FE_W-1:0];
    end
  end

  // Port output data
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      port_data <= SPF_RST_PORT_DATA;
    end else if (clk_en && reg_write &&
                 hit(reg_addr, SPF_OFS_PORT_DATA)) begin
      port_data <= reg_wdata[SPF_PADS-1:0];
    end
  end

  // Port direction, one means drive
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      port_dir <= SPF_RST_PORT_DIR;
    end else if (clk_en && reg_write &&
                 hit(reg_addr, SPF_OFS_PORT_DIR)) begin
      port_dir <= reg_wdata[SPF_PADS-1:0];
    end
  end

  // **************************************************************
  // Register reads
  // **************************************************************
  // Unmapped addresses read as zero; pad level shows all pads raw
  always_comb begin
    next_rdata = '0;
    if (hit(reg_addr, SPF_OFS_FUNC_EN)) begin
      next_rdata = {{(DATA_W-SPF_FE_W){1'b0}}, func_en};
    end else if (hit(reg_addr, SPF_OFS_PORT_DATA)) begin
      next_rdata = pad_word(port_data);
    end else if (hit(reg_addr, SPF_OFS_PORT_DIR)) begin
      next_rdata = pad_word(port_dir);
    end else if (hit(reg_addr, SPF_OFS_PAD_LEVEL)) begin
      next_rdata = pad_word(pad_in); // [R18]
    end else if (hit(reg_addr, SPF_OFS_PORT_OWN)) begin
      next_rdata = pad_word(port_own);
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= reg_read ? next_rdata : '0;
    end
  end

endmodule

// *** test/spf_chk.sv ***
// Concurrent checks on the shared pad function select ports
`timescale 1ns/100ps
module spf_chk
  import spf_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire spf_pkg::spf_periph_out_t periph_out,
  input wire spf_pkg::spf_periph_in_t periph_in,
  input wire logic [4:0] pad_in,
  input wire logic [4:0] pad_out,
  input wire logic [4:0] pad_oe
);
  logic [9:0] fe;
  logic [4:0] pd;
  logic [4:0] dir;
  logic [4:0] own;
  // Shadow settings rebuilt from bus writes only
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fe <= SPF_RST_FUNC_EN;
      pd <= SPF_RST_PORT_DATA;
      dir <= SPF_RST_PORT_DIR;
    end else if (clk_en && reg_write) begin
      if (reg_addr == SPF_OFS_FUNC_EN) fe <= reg_wdata[9:0];
      if (reg_addr == SPF_OFS_PORT_DATA) pd <= reg_wdata[4:0];
      if (reg_addr == SPF_OFS_PORT_DIR) dir <= reg_wdata[4:0];
    end
  end
  // Pads the port owns; an interrupt does not block pad 0
  assign own = {~fe[9], ~(fe[8] & fe[7]), ~(fe[6] & fe[5]),
    ~(fe[4] | fe[3]), ~(fe[1] | fe[0])};
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Outputs lag their causes by one enabled cycle
  a_pg5_drive: assert property ($past(clk_en && fe[0]) |->
    pad_oe[0] && pad_out[0] == $past(periph_out.pulse_gen_out_5))
    else $error("pad 0 pulse output wrong");
  a_b16_off: assert property ($past(clk_en && fe[1:0] == 2'b10) |->
    !pad_oe[0]) else $error("pad 0 driven during receive");
  a_can_rx: assert property ($past(clk_en) |->
    periph_in.can_receive_line == $past(fe[1] ? pad_in[0] : 1'b1))
    else $error("receive line wrong");
  a_irq_six: assert property ($past(clk_en) |->
    periph_in.ext_irq_line_6 == $past(fe[2] & pad_in[0]))
    else $error("interrupt line wrong");
  a_pg6_drive: assert property ($past(clk_en && fe[3]) |->
    pad_oe[1] && pad_out[1] == $past(periph_out.pulse_gen_out_6))
    else $error("pad 1 pulse output wrong");
  a_can_tx: assert property ($past(clk_en && fe[4:3] == 2'b10) |->
    pad_oe[1] && pad_out[1] == $past(periph_out.can_transmit_line))
    else $error("transmit line wrong");
  a_port_drive: assert property ($past(clk_en) |->
    (((pad_oe ^ $past(dir)) | (pad_out ^ $past(pd))) & $past(own)) == 5'h00)
    else $error("port drive wrong");
  a_trig_in: assert property ($past(clk_en) |->
    periph_in[4:0] == $past({fe[5], fe[6], fe[7], fe[8], fe[9]} &
    {pad_in[2], pad_in[2], pad_in[3], pad_in[3], pad_in[4]}))
    else $error("trigger inputs wrong");
  a_read_fe: assert property (clk_en && reg_read &&
    reg_addr == SPF_OFS_FUNC_EN |=> reg_rdata == {22'h0, $past(fe)})
    else $error("enable readback wrong");
  // Read data stands one cycle only, then returns to zero
  a_rdata_idle: assert property (clk_en && !reg_read |=>
    reg_rdata == 32'h0) else $error("read data not idle");
  // Enable low freezes every output
  a_freeze_all: assert property (!clk_en |=> $stable(pad_oe) &&
    $stable(pad_out) && $stable(periph_in) && $stable(reg_rdata))
    else $error("outputs moved with enable low");
  c_pg5: cover property (fe[0] && pad_oe[0]);
  c_trig: cover property (periph_in.capture_trigger_3);
  c_read: cover property (clk_en && reg_read);
endmodule
bind spf_pin_select spf_chk u_chk (.clock(clock), .reset_n(reset_n),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .periph_out(periph_out), .periph_in(periph_in), .pad_in(pad_in),
  .pad_out(pad_out), .pad_oe(pad_oe));

// *** test/spf_far_model.sv ***
// Board-side model of the five shared pads and peripheral drivers
`timescale 1ns/100ps
module spf_far_model
  import spf_pkg::*;
(
  input wire logic [4:0] pad_out,
  input wire logic [4:0] pad_oe,
  input wire logic [4:0] ext_level,
  input wire logic [2:0] pg_level,
  output logic [4:0] pad_in,
  output spf_pkg::spf_periph_out_t periph_out
);
  // Driven pads show the chip level, released pads the board level
  always_comb begin
    pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
    periph_out = pg_level;
  end
endmodule

// *** test/spf_pin_select_tb.sv ***
// Self-checking bench for the shared pad function select block
`timescale 1ns/100ps
module spf_pin_select_tb;
  import spf_pkg::*;
  logic clock = 0;
  logic reset_n = 0;
  logic clk_en = 1;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0;
  logic reg_write = 0;
  logic reg_read = 0;
  logic [31:0] reg_rdata;
  spf_periph_out_t periph_out;
  spf_periph_in_t periph_in;
  logic [4:0] pad_in;
  logic [4:0] pad_out;
  logic [4:0] pad_oe;
  logic [4:0] ext = 0;
  logic [2:0] pg = 0;
  logic rd_d = 0;
  logic snap = 0;
  logic [31:0] notes[$];
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  spf_pin_select DUT (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .periph_out(periph_out),
    .periph_in(periph_in), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe));
  spf_far_model far (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext),
    .pg_level(pg), .pad_in(pad_in), .periph_out(periph_out));
  initial forever #4 clock = ~clock;
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One-cycle strobes with a gap so no signal is set twice at one edge
  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    notes.push_back(e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
  endtask
  // Expected {oe, driven level, periph_in} for one setting
  function automatic logic [16:0] model(logic [9:0] f, logic [4:0] d,
    logic [4:0] r, logic [4:0] x, logic [2:0] g);
    logic [4:0] oe;
    logic [4:0] o;
    logic [4:0] p;
    o = {~f[9], ~(f[8] & f[7]), ~(f[6] & f[5]), ~(f[4] | f[3]),
      ~(f[1] | f[0])};
    oe = o & r;
    o = o & d;
    if (f[0]) {oe[0], o[0]} = {1'b1, g[2]};
    if (f[3] | f[4]) {oe[1], o[1]} = {1'b1, f[3] ? g[1] : g[0]};
    p = (oe & o) | (~oe & x);
    return {oe, o & oe, f[1] ? p[0] : 1'b1, f[2] & p[0], f[5] & p[2],
      f[6] & p[2], f[7] & p[3], f[8] & p[3], f[9] & p[4]};
  endfunction
  // Results are judged half a cycle after they settle
  always @(posedge clock) rd_d <= reg_read;
  always @(negedge clock) begin
    logic [31:0] n;
    if (rd_d) check("rdata", reg_rdata, notes.pop_front());
    if (snap) begin
      n = notes.pop_front();
      check("oe", pad_oe, n[16:12]);
      check("out", pad_out & pad_oe, n[11:7]);
      check("pin", periph_in, n[6:0]);
    end
  end
  // Hang guard well above the expected run length
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test;
    end
  end
  initial begin
    logic [31:0] w;
    logic [4:0] d;
    logic [4:0] r;
    logic [16:0] m;
    logic [4:0] o;
    w = $urandom(52757);
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    rd(SPF_OFS_FUNC_EN, 32'h0);
    rd(SPF_OFS_PORT_DIR, 32'h0);
    rd(8'h14, 32'h0);
    for (int i = 0; i < 40; i++) begin
      w = $urandom;
      if (i < 10) w = 32'h1 << i;
      d = $urandom;
      r = $urandom;
      r = r & ~{w[9], w[8] | w[7], w[6] | w[5], 1'b0, w[2] | w[1]};
      if (i % 7 == 3) r = 5'h1f;
      wr(SPF_OFS_FUNC_EN, w);
      wr(SPF_OFS_PORT_DATA, {27'h0, d});
      wr(SPF_OFS_PORT_DIR, {27'h0, r});
      ext <= $urandom;
      pg <= $urandom;
      repeat (3) @(posedge clock);
      m = model(w[9:0], d, r, ext, pg);
      notes.push_back({15'h0, m});
      snap <= 1'b1;
      @(posedge clock);
      snap <= 1'b0;
      rd(SPF_OFS_FUNC_EN, {22'h0, w[9:0]});
      rd(SPF_OFS_PORT_DATA, {27'h0, d});
      rd(SPF_OFS_PORT_DIR, {27'h0, r});
      // Ownership straight from the enables, pad level from the board
      o = {~w[9], ~(w[8] & w[7]), ~(w[6] & w[5]), ~(w[4] | w[3]),
        ~(w[1] | w[0])};
      rd(SPF_OFS_PORT_OWN, {27'h0, o});
      o = (m[16:12] & m[11:7]) | (~m[16:12] & ext);
      rd(SPF_OFS_PAD_LEVEL, {27'h0, o});
    end
    // Writes with the clock enable low must be lost
    clk_en <= 1'b0;
    wr(SPF_OFS_FUNC_EN, 32'h3ff);
    clk_en <= 1'b1;
    rd(SPF_OFS_FUNC_EN, {22'h0, w[9:0]});
    end_of_test;
  end
endmodule
